/* File: hw/rst_pkg.sv */
// constants for the reset cause recorder and debug force reset
// assumes an 8-bit register bus with 16-bit addresses on core_clk
package rst_pkg;
  localparam int          CLK_MHZ      = 25;
  localparam int          HOLD_NS      = 1600;
  localparam int          HOLD_CYC     = (HOLD_NS * CLK_MHZ + 999) / 1000;
  localparam int          CNT_W        = 8;
  localparam logic [7:0]  HOLD_LAST    = 8'(HOLD_CYC - 1);
  localparam logic [7:0]  CNT_ZERO     = 8'h00;
  localparam logic [7:0]  CNT_STEP     = 8'h01;
  localparam logic [15:0] CAUSE_ADDR   = 16'h1800;
  localparam logic [15:0] DEBUG_ADDR   = 16'h1801;
  localparam logic [15:0] GAP0_LO      = 16'h0470;
  localparam logic [15:0] GAP0_HI      = 16'h17ff;
  localparam logic [15:0] GAP1_LO      = 16'h1860;
  localparam logic [15:0] GAP1_HI      = 16'hbfff;
  localparam int          POR_BIT      = 7;
  localparam int          PIN_BIT      = 6;
  localparam int          WDOG_BIT     = 5;
  localparam int          BADOP_BIT    = 4;
  localparam int          BADADDR_BIT  = 3;
  localparam int          CLKGEN_BIT   = 2;
  localparam int          LOWV_BIT     = 1;
  localparam int          FORCE_BIT    = 0;
  localparam logic [7:0]  POR_MASK     = 8'h80;
  localparam logic [7:0]  LOWV_MASK    = 8'h02;
  localparam logic [7:0]  CAUSE_POR    = 8'h82;
  localparam logic [7:0]  ZERO_BYTE    = 8'h00;
  localparam logic [2:0]  SYNC_IDLE    = 3'h0;
  typedef enum logic {ST_RUN, ST_HOLD} seq_state_e;
endpackage

/* File: hw/sync_if.sv */
// synchronised levels passed from the input synchroniser to the recorder
// assumes both ends run on core_clk
`timescale 1ns/1ns
interface sync_if;
  logic pin_low;
  logic lowv_low;
  logic clkgen_req;
  modport src (output pin_low, output lowv_low, output clkgen_req);
  modport dst (input pin_low, input lowv_low, input clkgen_req);
endinterface

/* File: hw/input_sync.sv */
// three-flop synchronisers for the asynchronous reset sources
// assumes raw inputs come from pins or analog detectors
`timescale 1ns/1ns
module input_sync (
  input  wire logic core_clk,
  input  wire logic nrst,
  input  wire logic rst_pin_n,
  input  wire logic lowv_trip,
  input  wire logic clkgen_rst_req,
  sync_if.src       sync
);
  logic [2:0] pin_ff_reg,  pin_ff_next;
  logic [2:0] lv_ff_reg,   lv_ff_next;
  logic [2:0] cg_ff_reg,   cg_ff_next;
  logic       pin_reg,     pin_next;
  logic       lv_reg,      lv_next;
  logic       cg_reg,      cg_next;

  // a change counts once the second and third flops agree
  always_comb begin
    pin_ff_next = {pin_ff_reg[1:0], ~rst_pin_n};
    lv_ff_next  = {lv_ff_reg[1:0], lowv_trip};
    cg_ff_next  = {cg_ff_reg[1:0], clkgen_rst_req};
    pin_next    = (pin_ff_reg[1] == pin_ff_reg[2]) ? pin_ff_reg[2] : pin_reg;
    lv_next     = (lv_ff_reg[1] == lv_ff_reg[2]) ? lv_ff_reg[2] : lv_reg;
    cg_next     = (cg_ff_reg[1] == cg_ff_reg[2]) ? cg_ff_reg[2] : cg_reg;
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      pin_ff_reg <= rst_pkg::SYNC_IDLE;
      lv_ff_reg  <= rst_pkg::SYNC_IDLE;
      cg_ff_reg  <= rst_pkg::SYNC_IDLE;
      pin_reg    <= 1'b0;
      lv_reg     <= 1'b0;
      cg_reg     <= 1'b0;
    end else begin
      pin_ff_reg <= pin_ff_next;
      lv_ff_reg  <= lv_ff_next;
      cg_ff_reg  <= cg_ff_next;
      pin_reg    <= pin_next;
      lv_reg     <= lv_next;
      cg_reg     <= cg_next;
    end
  end

  assign sync.pin_low    = pin_reg;
  assign sync.lowv_low   = lv_reg;
  assign sync.clkgen_req = cg_reg;
endmodule // input_sync

/* File: hw/reset_cause_and_debug_reset.sv */
// reset cause recorder, reset sequencer and debug force reset
// assumes nrst is the power-on reset and bus strobes are one-cycle pulses
// Overview of operation
// - seven read-only cause flags record the last reset source; bit 0 always zero
// - a reset forced by the debug host leaves every cause flag cleared
// - a write to the cause register outside reset restarts the watchdog, flags unchanged
// - power-on reset sets power-on and low-voltage flags, clears the others
// - low-voltage reset keeps power-on flag, sets low-voltage, clears the rest
// - other resets set flags of active sources, clear power-on and low-voltage
// - a low level on the reset pin sets the pin flag
// - watchdog disabled means no watchdog reset and no watchdog flag
// - stop instruction with stop disabled gives an illegal-opcode reset
// - background instruction with background mode disabled gives an illegal-opcode reset
// - access inside either unmapped address gap resets with the illegal-address flag
// - unused locations inside register areas never count as illegal addresses
// - a clock generator reset request sets the clock-generator flag
// - low-voltage reset needs both enables set and supply below trip level
// - user program writes to the debug force-reset register are ignored
// - reads of the debug force-reset register always return zero
// - debug path writing 1 to bit 0 forces a full reset
// - watchdog enable is the watchdog_enable input, used as given with no write-once logic or default
`timescale 1ns/1ns
module reset_cause_and_debug_reset (
  input  wire logic        core_clk,
  input  wire logic        nrst,
  input  wire logic [15:0] bus_addr,
  input  wire logic        bus_rd,
  input  wire logic        bus_wr,
  input  wire logic        bus_bdm,
  input  wire logic [7:0]  bus_wdata,
  output logic      [7:0]  bus_rdata,
  input  wire logic        rst_pin_n,
  input  wire logic        lowv_trip,
  input  wire logic        clkgen_rst_req,
  input  wire logic        wdog_timeout,
  input  wire logic        watchdog_enable,
  input  wire logic        bad_opcode,
  input  wire logic        stop_exec,
  input  wire logic        stop_enable,
  input  wire logic        enter_background_instr,
  input  wire logic        background_mode_enable,
  input  wire logic        lowv_reset_enable,
  input  wire logic        lowv_stop_enable,
  output logic             mcu_rst,
  output logic             wdog_restart
);
  sync_if sync ();

  input_sync u_sync (
    .core_clk       (core_clk),
    .nrst           (nrst),
    .rst_pin_n      (rst_pin_n),
    .lowv_trip      (lowv_trip),
    .clkgen_rst_req (clkgen_rst_req),
    .sync           (sync)
  );

  rst_pkg::seq_state_e state_reg, state_next;
  logic [7:0]          cnt_reg, cnt_next;
  logic [7:0]          cause_reg, cause_next;
  logic [7:0]          rdata_reg, rdata_next;
  logic                rst_reg, rst_next;
  logic                restart_reg, restart_next;
  logic                trig_pin, trig_wdog, trig_badop, trig_badaddr;
  logic                trig_clkgen, trig_lowv, trig_dbg, trig_any;
  logic                in_run, cause_wr, debug_wr;

  function automatic logic in_gap(input logic [15:0] a);
    in_gap = ((a >= rst_pkg::GAP0_LO) && (a <= rst_pkg::GAP0_HI)) ||
             ((a >= rst_pkg::GAP1_LO) && (a <= rst_pkg::GAP1_HI));
  endfunction

  // reset source qualification
  always_comb begin
    in_run    = (state_reg == rst_pkg::ST_RUN);
    cause_wr  = bus_wr && (bus_addr == rst_pkg::CAUSE_ADDR);
    debug_wr  = bus_wr && bus_bdm && (bus_addr == rst_pkg::DEBUG_ADDR);
    trig_pin  = sync.pin_low;
    trig_wdog = wdog_timeout && watchdog_enable;
    trig_badop = bad_opcode ||
                 (stop_exec && !stop_enable) ||
                 (enter_background_instr && !background_mode_enable);
    trig_badaddr = (bus_rd || bus_wr) && in_gap(bus_addr);
    trig_clkgen = sync.clkgen_req;
    trig_lowv = lowv_reset_enable && lowv_stop_enable && sync.lowv_low;
    trig_dbg  = debug_wr && bus_wdata[rst_pkg::FORCE_BIT];
    trig_any  = trig_pin || trig_wdog || trig_badop || trig_badaddr ||
                trig_clkgen || trig_lowv || trig_dbg;
  end

  // reset sequencer and cause capture
  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    cause_next = cause_reg;
    unique case (state_reg)
      rst_pkg::ST_RUN: begin
        if (trig_any) begin
          state_next = rst_pkg::ST_HOLD;
          cnt_next   = rst_pkg::HOLD_LAST;
          if (trig_lowv) begin
            cause_next = (cause_reg & rst_pkg::POR_MASK) | rst_pkg::LOWV_MASK;
          end else begin
            cause_next                       = rst_pkg::ZERO_BYTE;
            cause_next[rst_pkg::PIN_BIT]     = trig_pin;
            cause_next[rst_pkg::WDOG_BIT]    = trig_wdog;
            cause_next[rst_pkg::BADOP_BIT]   = trig_badop;
            cause_next[rst_pkg::BADADDR_BIT] = trig_badaddr;
            cause_next[rst_pkg::CLKGEN_BIT]  = trig_clkgen;
          end
        end
      end
      rst_pkg::ST_HOLD: begin
        if (cnt_reg != rst_pkg::CNT_ZERO) begin
          cnt_next = cnt_reg - rst_pkg::CNT_STEP;
        end else if (!sync.pin_low) begin
          state_next = rst_pkg::ST_RUN;
        end
      end
    endcase
  end

  // register reads and watchdog restart
  always_comb begin
    rst_next     = (state_next == rst_pkg::ST_HOLD);
    restart_next = in_run && cause_wr;
    rdata_next   = rst_pkg::ZERO_BYTE;
    if (bus_rd && (bus_addr == rst_pkg::CAUSE_ADDR)) begin
      rdata_next = cause_reg;
    end else if (bus_rd && (bus_addr == rst_pkg::DEBUG_ADDR)) begin
      rdata_next = rst_pkg::ZERO_BYTE;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      state_reg   <= rst_pkg::ST_HOLD;
      cnt_reg     <= rst_pkg::HOLD_LAST;
      cause_reg   <= rst_pkg::CAUSE_POR;
      rdata_reg   <= rst_pkg::ZERO_BYTE;
      rst_reg     <= 1'b1;
      restart_reg <= 1'b0;
    end else begin
      state_reg   <= state_next;
      cnt_reg     <= cnt_next;
      cause_reg   <= cause_next;
      rdata_reg   <= rdata_next;
      rst_reg     <= rst_next;
      restart_reg <= restart_next;
    end
  end

  assign bus_rdata    = rdata_reg;
  assign mcu_rst      = rst_reg;
  assign wdog_restart = restart_reg;

  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  property p_bit0_zero;
    cause_reg[rst_pkg::FORCE_BIT] == 1'b0;
  endproperty
  a_bit0_zero: assert property (p_bit0_zero) else $error("cause bit 0 set");

  property p_dbg_clear;
    in_run && trig_dbg && !(trig_pin || trig_wdog || trig_badop || trig_badaddr ||
      trig_clkgen || trig_lowv) |=> (cause_reg == rst_pkg::ZERO_BYTE) && mcu_rst;
  endproperty
  a_dbg_clear: assert property (p_dbg_clear) else $error("debug reset left flags");

  property p_wr_restart;
    in_run && cause_wr && !trig_any |=> wdog_restart && $stable(cause_reg);
  endproperty
  a_wr_restart: assert property (p_wr_restart) else $error("cause write no restart");

  property p_por;
    $rose(nrst) |-> (cause_reg == rst_pkg::CAUSE_POR) && mcu_rst;
  endproperty
  a_por: assert property (p_por) else $error("power-on pattern wrong");

  property p_lvr;
    in_run && trig_lowv |=> cause_reg[rst_pkg::LOWV_BIT] &&
      (cause_reg[rst_pkg::POR_BIT] == $past(cause_reg[rst_pkg::POR_BIT])) &&
      ((cause_reg & ~(rst_pkg::POR_MASK | rst_pkg::LOWV_MASK)) == rst_pkg::ZERO_BYTE);
  endproperty
  a_lvr: assert property (p_lvr) else $error("low-voltage pattern wrong");

  property p_other;
    in_run && trig_any && !trig_lowv |=> !cause_reg[rst_pkg::POR_BIT] &&
      !cause_reg[rst_pkg::LOWV_BIT] && (cause_reg[rst_pkg::WDOG_BIT] == $past(trig_wdog));
  endproperty
  a_other: assert property (p_other) else $error("other reset pattern wrong");

  property p_wdog_gate;
    in_run && trig_any && !watchdog_enable |=> !cause_reg[rst_pkg::WDOG_BIT];
  endproperty
  a_wdog_gate: assert property (p_wdog_gate) else $error("watchdog flag while off");

  property p_stop;
    in_run && stop_exec && !stop_enable && !trig_lowv |=> cause_reg[rst_pkg::BADOP_BIT];
  endproperty
  a_stop: assert property (p_stop) else $error("stop not illegal");

  property p_gap1;
    in_run && (bus_rd || bus_wr) && (bus_addr == rst_pkg::GAP1_LO) && !trig_lowv
      |=> cause_reg[rst_pkg::BADADDR_BIT] && mcu_rst;
  endproperty
  a_gap1: assert property (p_gap1) else $error("gap access not caught");

  property p_dbg_read;
    bus_rd && (bus_addr == rst_pkg::DEBUG_ADDR) |=> bus_rdata == rst_pkg::ZERO_BYTE;
  endproperty
  a_dbg_read: assert property (p_dbg_read) else $error("debug register read nonzero");

  property p_user_wr;
    in_run && bus_wr && !bus_bdm && (bus_addr == rst_pkg::DEBUG_ADDR) &&
      !trig_any |=> !mcu_rst;
  endproperty
  a_user_wr: assert property (p_user_wr) else $error("user write forced reset");

  property p_hold;
    (state_reg == rst_pkg::ST_HOLD) |-> mcu_rst ##1 $stable(cause_reg);
  endproperty
  a_hold: assert property (p_hold) else $error("flags moved during reset");

  property p_por_outs;
    $rose(nrst) |-> (bus_rdata == rst_pkg::ZERO_BYTE) && !wdog_restart;
  endproperty
  a_por_outs: assert property (p_por_outs) else $error("outputs wrong after power-on");

  property p_pin;
    in_run && sync.pin_low && !trig_lowv |=> cause_reg[rst_pkg::PIN_BIT] && mcu_rst;
  endproperty
  a_pin: assert property (p_pin) else $error("pin reset not flagged");

  property p_badop;
    in_run && bad_opcode && !trig_lowv |=> cause_reg[rst_pkg::BADOP_BIT] && mcu_rst;
  endproperty
  a_badop: assert property (p_badop) else $error("bad opcode not flagged");

  property p_wdog_set;
    in_run && wdog_timeout && watchdog_enable && !trig_lowv
      |=> cause_reg[rst_pkg::WDOG_BIT] && mcu_rst;
  endproperty
  a_wdog_set: assert property (p_wdog_set) else $error("watchdog reset not flagged");

  property p_background;
    in_run && enter_background_instr && !background_mode_enable && !trig_lowv
      |=> cause_reg[rst_pkg::BADOP_BIT];
  endproperty
  a_background: assert property (p_background) else $error("background not illegal");

  property p_gap0;
    in_run && (bus_rd || bus_wr) && (bus_addr == rst_pkg::GAP0_LO) && !trig_lowv
      |=> cause_reg[rst_pkg::BADADDR_BIT] && mcu_rst;
  endproperty
  a_gap0: assert property (p_gap0) else $error("low gap access not caught");

  property p_regs_legal;
    (bus_rd || bus_wr) && (bus_addr > rst_pkg::GAP0_HI) && (bus_addr < rst_pkg::GAP1_LO)
      |-> !trig_badaddr;
  endproperty
  a_regs_legal: assert property (p_regs_legal) else $error("register access flagged");

  property p_clkgen;
    in_run && sync.clkgen_req && !trig_lowv |=> cause_reg[rst_pkg::CLKGEN_BIT];
  endproperty
  a_clkgen: assert property (p_clkgen) else $error("clock reset not flagged");

  property p_lowv_gate;
    in_run && trig_any && !(lowv_reset_enable && lowv_stop_enable)
      |=> !cause_reg[rst_pkg::LOWV_BIT];
  endproperty
  a_lowv_gate: assert property (p_lowv_gate) else $error("low-voltage flag while off");

  property p_restart_src;
    wdog_restart |-> $past(cause_wr) && $past(in_run);
  endproperty
  a_restart_src: assert property (p_restart_src) else $error("restart without write");

  property p_hold_restart;
    (state_reg == rst_pkg::ST_HOLD) |=> !wdog_restart;
  endproperty
  a_hold_restart: assert property (p_hold_restart) else $error("restart during reset");

  property p_rd_cause;
    bus_rd && (bus_addr == rst_pkg::CAUSE_ADDR) |=> bus_rdata == $past(cause_reg);
  endproperty
  a_rd_cause: assert property (p_rd_cause) else $error("cause read wrong");

  property p_run_stable;
    in_run && !trig_any |=> $stable(cause_reg) && !mcu_rst;
  endproperty
  a_run_stable: assert property (p_run_stable) else $error("flags moved while running");

  property p_dbg_len;
    in_run && trig_dbg |=> mcu_rst [*8];
  endproperty
  a_dbg_len: assert property (p_dbg_len) else $error("debug reset too short");

  property p_dbg_bit0;
    in_run && debug_wr && !bus_wdata[rst_pkg::FORCE_BIT] && !trig_pin && !trig_wdog &&
      !trig_badop && !trig_badaddr && !trig_clkgen && !trig_lowv |=> !mcu_rst;
  endproperty
  a_dbg_bit0: assert property (p_dbg_bit0) else $error("debug zero forced reset");
endmodule // reset_cause_and_debug_reset

/* File: dv/debug_host_model.sv */
// debug host model: background memory writes onto the register bus
// assumes the bench merges these lines with the processor bus
`timescale 1ns/1ns
module debug_host_model (
  input  wire logic        core_clk,
  output logic             host_wr,
  output logic      [15:0] host_addr,
  output logic      [7:0]  host_data
);
  initial begin
    host_wr   = 1'b0;
    host_addr = 16'h0000;
    host_data = 8'h00;
  end
  // released lines show the inverse of the last value
  task automatic bg_write(input logic [15:0] a, input logic [7:0] v);
    @(posedge core_clk);
    host_wr   <= 1'b1;
    host_addr <= a;
    host_data <= v;
    @(posedge core_clk);
    host_wr   <= 1'b0;
    host_addr <= ~a;
    host_data <= ~v;
  endtask
endmodule // debug_host_model

/* File: dv/reset_cause_and_debug_reset_bench.sv */
// bench for the reset cause recorder and debug force reset
// assumes the design package and the debug host model are compiled first
`timescale 1ns/1ns
module reset_cause_and_debug_reset_bench;
  logic        core_clk, nrst, cpu_rd, cpu_wr, mcu_rst, wdog_restart, host_wr;
  logic [15:0] cpu_addr, host_addr;
  logic [7:0]  cpu_data, host_data, bus_rdata, d;
  logic [6:0]  trg;
  logic [4:0]  opt;
  int          errors, compares;

  debug_host_model debug_host_model_inst (.core_clk(core_clk), .host_wr(host_wr),
    .host_addr(host_addr), .host_data(host_data));
  reset_cause_and_debug_reset reset_cause_and_debug_reset_inst (
    .core_clk(core_clk), .nrst(nrst), .bus_rd(cpu_rd), .bus_wr(cpu_wr | host_wr),
    .bus_addr(host_wr ? host_addr : cpu_addr), .bus_bdm(host_wr),
    .bus_wdata(host_wr ? host_data : cpu_data), .bus_rdata(bus_rdata),
    .rst_pin_n(~trg[0]), .lowv_trip(trg[1]), .clkgen_rst_req(trg[2]),
    .wdog_timeout(trg[3]), .stop_exec(trg[4]), .enter_background_instr(trg[5]),
    .bad_opcode(trg[6]),
    .watchdog_enable(opt[4]), .stop_enable(opt[3]), .background_mode_enable(opt[2]),
    .lowv_reset_enable(opt[1]), .lowv_stop_enable(opt[0]),
    .mcu_rst(mcu_rst), .wdog_restart(wdog_restart));

  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  task automatic wrap_up;
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic rd(input logic [15:0] a);
    @(posedge core_clk);
    cpu_rd   <= 1'b1;
    cpu_addr <= a;
    @(posedge core_clk);
    cpu_rd <= 1'b0;
    #1 d = bus_rdata;
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] v);
    @(posedge core_clk);
    cpu_wr   <= 1'b1;
    cpu_addr <= a;
    cpu_data <= v;
    @(posedge core_clk);
    cpu_wr <= 1'b0;
    #1;
  endtask

  task automatic settle;
    int n;
    n = 0;
    while (mcu_rst !== 1'b0 && n < 100) begin
      @(posedge core_clk);
      #1 n++;
    end
    if (mcu_rst !== 1'b0) begin
      errors++;
      $display("[ERR] %0t reset never ended", $time);
    end
  endtask

  // waits up to 10 cycles for a reset, checks it against hit, and if one is expected reads the cause flags once it is over
  task automatic expect_rst(input logic hit, input logic [7:0] cause);
    int n;
    n = 0;
    while (mcu_rst !== 1'b1 && n < 10) begin
      @(posedge core_clk);
      #1 n++;
    end
    @(posedge core_clk);
    trg <= 7'h00;
    #1 chk({7'h00, mcu_rst}, {7'h00, hit});
    if (hit) begin
      settle();
      rd(rst_pkg::CAUSE_ADDR);
      chk(d, cause);
    end
  endtask

  task automatic fire(input logic [6:0] t, input logic [4:0] o, input logic hit,
                      input logic [7:0] cause);
    @(posedge core_clk);
    trg <= t;
    opt <= o;
    expect_rst(hit, cause);
  endtask

  task automatic t_regs;
    rd(rst_pkg::CAUSE_ADDR);
    chk(d, 8'h82);
    wr(rst_pkg::CAUSE_ADDR, 8'h00);
    chk({7'h00, wdog_restart}, 8'h01);
    rd(rst_pkg::CAUSE_ADDR);
    chk(d, 8'h82);
    fire(7'h02, 5'h1f, 1'b1, 8'h82);
  endtask

  task automatic t_debug;
    rd(rst_pkg::DEBUG_ADDR);
    chk(d, 8'h00);
    debug_host_model_inst.bg_write(rst_pkg::DEBUG_ADDR, 8'hfe);
    expect_rst(1'b0, 8'h00);
    rd(rst_pkg::DEBUG_ADDR);
    chk(d, 8'h00);
    wr(rst_pkg::DEBUG_ADDR, 8'h01);
    expect_rst(1'b0, 8'h00);
    debug_host_model_inst.bg_write(rst_pkg::DEBUG_ADDR, 8'h01);
    expect_rst(1'b1, 8'h00);
  endtask

  task automatic t_sources;
    fire(7'h02, 5'h1f, 1'b1, 8'h02);
    fire(7'h01, 5'h1f, 1'b1, 8'h40);
    fire(7'h02, 5'h1e, 1'b0, 8'h00);
    fire(7'h02, 5'h1d, 1'b0, 8'h00);
    fire(7'h02, 5'h1f, 1'b1, 8'h02);
    fire(7'h08, 5'h0f, 1'b0, 8'h00);
    fire(7'h08, 5'h1f, 1'b1, 8'h20);
    fire(7'h10, 5'h1f, 1'b0, 8'h00);
    fire(7'h10, 5'h17, 1'b1, 8'h10);
    fire(7'h20, 5'h1f, 1'b0, 8'h00);
    fire(7'h20, 5'h1b, 1'b1, 8'h10);
    fire(7'h04, 5'h1f, 1'b1, 8'h04);
    fire(7'h40, 5'h1f, 1'b1, 8'h10);
    fire(7'h48, 5'h0c, 1'b1, 8'h10);
  endtask

  task automatic t_gaps;
    logic [15:0] bad [4];
    logic [15:0] ok [3];
    bad = '{16'h0470, 16'h17ff, 16'h1860, 16'hbfff};
    ok  = '{16'h046f, 16'h185f, 16'hc000};
    foreach (bad[i]) begin
      rd(bad[i]);
      expect_rst(1'b1, 8'h08);
    end
    foreach (ok[i]) begin
      rd(ok[i]);
      expect_rst(1'b0, 8'h00);
    end
  endtask

  initial begin
    nrst     = 1'b0;
    cpu_rd   = 1'b0;
    cpu_wr   = 1'b0;
    cpu_addr = 16'h0000;
    cpu_data = 8'h00;
    trg      = 7'h00;
    opt      = 5'h1f;
    errors   = 0;
    compares = 0;
    repeat (12) @(posedge core_clk);
    nrst <= 1'b1;
    settle();
    t_regs();
    t_debug();
    t_sources();
    t_gaps();
    wrap_up();
  end

  initial begin
    #400000;
    errors++;
    wrap_up();
  end
endmodule // reset_cause_and_debug_reset_bench
